// file: pkg/hssp_defines.vh
// Purpose: constants of the host serial system port
// Assumes: 100 MHz system clock
// Notes: offsets are short-form register addresses
`ifndef HSSP_DEFINES_VH
`define HSSP_DEFINES_VH

// register offsets
`define HSSP_REG_RESET_CTRL   6'h00
`define HSSP_REG_FSM_RESET    6'h01
`define HSSP_REG_OP_STATE     6'h02
`define HSSP_REG_DEV_COND     6'h03
`define HSSP_REG_FLAGS_SYS    6'h04
`define HSSP_REG_FLAGS_MISC   6'h07
`define HSSP_REG_EN_SYS       6'h08
`define HSSP_REG_EN_MISC      6'h0b
`define HSSP_REG_PIN_CTRL     6'h0c
`define HSSP_REG_PIN_DIR_DATA 6'h0d
`define HSSP_REG_PIN_POL_TRIG 6'h0e
`define HSSP_REG_PIN_PULL     6'h0f

// writable bits, reserved bits read zero
`define HSSP_WMASK_RESET_CTRL 8'h3f
`define HSSP_WMASK_FSM_RESET  8'h1f
`define HSSP_WMASK_OP_STATE   8'h7f
`define HSSP_WMASK_SYS        8'h36
`define HSSP_WMASK_TX         8'hff
`define HSSP_WMASK_RX         8'hef
`define HSSP_WMASK_MISC       8'hff
`define HSSP_WMASK_PIN_CTRL   8'h4f
`define HSSP_WMASK_PIN_DIR    8'hf7
`define HSSP_WMASK_PIN_POL    8'h77
`define HSSP_WMASK_PIN_PULL   8'h77
`define HSSP_RESET_VALUE      8'h00

// field positions
`define HSSP_BIT_READY        5
`define HSSP_BIT_GIE          6
`define HSSP_BIT_IRQ_PEND     4
`define HSSP_BIT_PIN_EN       7
`define HSSP_BIT_INIT_DONE    7
`define HSSP_BIT_CAL_BUSY     4
`define HSSP_BIT_DEEP_SLEEP   2

// command byte
`define HSSP_CMD_LONG_BIT     7
`define HSSP_CMD_LONG_WR_BIT  6

// calibration time after reset release
`define HSSP_CLK_PERIOD_NS    10
`define HSSP_CAL_TIME_NS      20000
`define HSSP_CAL_CYCLES       ((`HSSP_CAL_TIME_NS + `HSSP_CLK_PERIOD_NS - 1) / `HSSP_CLK_PERIOD_NS)

`endif

// file: rtl/hssp_system_port.v
// Purpose: host serial port, interrupt pin and three general pins
// Assumes: serial pins, reset pin and pins are asynchronous, two-flop synced
// Notes: link clock is oversampled; host sck period must exceed 8 system clocks
//
// How it works
// (R1) interrupt pin driven low when pending
// (R2) only enabled, globally unmasked flags assert pin
// (R3) per-pin direction bit at 0x0D
// (R4) data bits read levels, write output levels
// (R5) per-pin interrupt edge polarity at 0x0E
// (R6) per-pin schmitt enable filters inputs
// (R7) four-bit monitor select routes internal signals
// (R8) slave mode 0,0, sck idles low
// (R9) host holds chip select low whole transfer
// (R10) sample data in on sck rise
// (R11) change data out on sck fall
// (R12) data out released in deep sleep
// (R13) short form: one byte, first 64 registers
// (R14) long form: two address bytes, whole map
// (R15) reset pin low resets, release starts calibration
// (R16) ready flag set when calibration ends
// (R17) command byte carries direction and address form
// (R18) reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "hssp_defines.vh"

module hssp_system_port #(
  parameter CAL_CYCLES = `HSSP_CAL_CYCLES,
  parameter MON_WIDTH = 48
) (
  input wire clk_i,
  input wire rst_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire sdi_i,
  input wire [2:0] pin_i,
  input wire [31:0] evt_i,
  input wire [MON_WIDTH-1:0] mon_i,
  input wire deep_sleep_i,
  output reg sdo_o,
  output reg sdo_oe_n_o,
  output reg int_n_o,
  output reg [2:0] pin_o,
  output reg [2:0] pin_oe_n_o
);

  localparam ST_CMD = 3'b001;
  localparam ST_ADRL = 3'b010;
  localparam ST_DATA = 3'b100;

  // synchronisers: stage one feeds stage two only
  reg [6:0] sync1;
  reg [6:0] sync2;
  reg sck_d;
  wire cs_s = sync2[0];
  wire sck_s = sync2[1];
  wire sdi_s = sync2[2];
  wire rst_pin_n_s = sync2[3];
  wire [2:0] pin_s = sync2[6:4];
  wire sck_rise = sck_s & ~sck_d; // (R10)
  wire sck_fall = ~sck_s & sck_d; // (R11)

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // idle levels: deselected and reset pin high, so no false soft reset
      sync1 <= 7'h09;
      sync2 <= 7'h09;
      sck_d <= 1'b0; // (R8)
    end else begin
      sync1 <= {pin_i, reset_n_i, sdi_i, sck_i, cs_n_i};
      sync2 <= sync1;
      sck_d <= sck_s;
    end
  end

  // register storage
  reg [7:0] reset_ctrl;
  reg [7:0] fsm_reset;
  reg [7:0] op_state;
  reg [7:0] flags [0:3];
  reg [7:0] enables [0:3];
  reg [7:0] pin_ctrl;
  reg [7:0] pin_dir_data;
  reg [7:0] pin_pol_trig;
  reg [7:0] pin_pull;
  reg [2:0] pin_lvl;
  reg [2:0] pin_prev;
  reg [2:0] pin_lvl_d;
  reg cal_busy;
  reg init_done;
  reg [31:0] cal_cnt;

  function [7:0] wmask;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: wmask = `HSSP_WMASK_SYS;
        2'd1: wmask = `HSSP_WMASK_TX;
        2'd2: wmask = `HSSP_WMASK_RX;
        default: wmask = `HSSP_WMASK_MISC;
      endcase
    end
  endfunction

  wire pending = |(flags[0] & enables[0]) | |(flags[1] & enables[1]) |
                 |(flags[2] & enables[2]) | |(flags[3] & enables[3]);

  // read view; everything above the implemented block reads zero
  function [7:0] reg_read;
    input [13:0] a;
    begin
      reg_read = 8'h00;
      if (a[13:4] != 10'h000) begin
        reg_read = 8'h00; // (R18)
      end else if (a[3:0] == `HSSP_REG_RESET_CTRL) begin
        reg_read = reset_ctrl;
      end else if (a[3:0] == `HSSP_REG_FSM_RESET) begin
        reg_read = fsm_reset;
      end else if (a[3:0] == `HSSP_REG_OP_STATE) begin
        reg_read = op_state;
      end else if (a[3:0] == `HSSP_REG_DEV_COND) begin
        reg_read = {init_done, 2'b00, cal_busy, 1'b0, deep_sleep_i, 2'b00};
      end else if (a[3:2] == 2'b01) begin
        reg_read = flags[a[1:0]];
      end else if (a[3:2] == 2'b10) begin
        reg_read = enables[a[1:0]];
      end else if (a[3:0] == `HSSP_REG_PIN_CTRL) begin
        reg_read = {1'b0, pin_ctrl[`HSSP_BIT_GIE], 1'b0, pending, pin_ctrl[3:0]};
      end else if (a[3:0] == `HSSP_REG_PIN_DIR_DATA) begin
        reg_read = {pin_dir_data[7:4], 1'b0, pin_lvl}; // (R4)
      end else if (a[3:0] == `HSSP_REG_PIN_POL_TRIG) begin
        reg_read = pin_pol_trig;
      end else begin
        reg_read = pin_pull;
      end
    end
  endfunction

  // serial engine
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [6:0] sh_in;
  reg [7:0] tx_sh;
  reg [13:0] addr;
  reg is_write;
  wire [7:0] rx_byte = {sh_in, sdi_s};
  wire byte_done = ~cs_s & sck_rise & (bit_cnt == 3'd7);
  wire wr_en = byte_done & state[2] & is_write;
  wire [13:0] next_addr = addr + 14'h0001;
  reg [13:0] rd_addr;

  always @* begin
    if (state[0]) begin
      rd_addr = {8'h00, rx_byte[6:1]}; // (R13)
    end else if (state[1]) begin
      rd_addr = {addr[13:8], rx_byte}; // (R14)
    end else begin
      rd_addr = next_addr;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_CMD;
      bit_cnt <= 3'd0;
      sh_in <= 7'h00;
      tx_sh <= 8'h00;
      addr <= 14'h0000;
      is_write <= 1'b0;
      sdo_o <= 1'b0;
    end else if (cs_s) begin
      state <= ST_CMD; // (R9)
      bit_cnt <= 3'd0;
      tx_sh <= 8'h00;
      sdo_o <= 1'b0;
    end else if (sck_rise) begin
      sh_in <= rx_byte[6:0]; // (R10)
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        tx_sh <= reg_read(rd_addr);
        case (state)
          ST_CMD: begin
            if (!rx_byte[`HSSP_CMD_LONG_BIT]) begin
              addr <= rd_addr; // (R17)
              is_write <= rx_byte[0];
              state <= ST_DATA;
            end else begin
              addr <= {rx_byte[5:0], 8'h00}; // (R17)
              is_write <= rx_byte[`HSSP_CMD_LONG_WR_BIT];
              state <= ST_ADRL;
            end
          end
          ST_ADRL: begin
            addr <= rd_addr; // (R14)
            state <= ST_DATA;
          end
          default: begin
            addr <= next_addr;
            state <= ST_DATA;
          end
        endcase
      end
    end else if (sck_fall) begin
      sdo_o <= tx_sh[7]; // (R11)
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // register writes, flags, calibration
  wire soft_rst = ~rst_pin_n_s; // (R15)
  wire [13:0] wa = addr;
  wire [7:0] wd = rx_byte;
  wire hit_low = wr_en & (wa[13:4] == 10'h000);
  wire [2:0] pin_rise = pin_lvl & ~pin_lvl_d;
  wire [2:0] pin_fall = ~pin_lvl & pin_lvl_d;
  wire [2:0] pin_evt = (pin_pol_trig[6:4] & pin_rise) | (~pin_pol_trig[6:4] & pin_fall); // (R5)
  wire ready_evt = cal_busy & (cal_cnt == CAL_CYCLES - 1); // (R16)
  reg [7:0] set_bits [0:3];
  integer i;
  integer j;

  always @* begin
    set_bits[0] = evt_i[7:0];
    set_bits[0][`HSSP_BIT_READY] = evt_i[`HSSP_BIT_READY] | ready_evt; // (R16)
    set_bits[1] = evt_i[15:8];
    set_bits[2] = evt_i[23:16];
    set_bits[3] = {evt_i[31:27], evt_i[26:24] | pin_evt}; // (R5)
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_ctrl <= `HSSP_RESET_VALUE;
      fsm_reset <= `HSSP_RESET_VALUE;
      op_state <= `HSSP_RESET_VALUE;
      pin_ctrl <= `HSSP_RESET_VALUE;
      pin_dir_data <= `HSSP_RESET_VALUE;
      pin_pol_trig <= `HSSP_RESET_VALUE;
      pin_pull <= `HSSP_RESET_VALUE;
      for (i = 0; i < 4; i = i + 1) begin
        flags[i] <= `HSSP_RESET_VALUE;
        enables[i] <= `HSSP_RESET_VALUE;
      end
      cal_busy <= 1'b1;
      init_done <= 1'b0;
      cal_cnt <= 32'd0;
    end else if (soft_rst) begin
      reset_ctrl <= `HSSP_RESET_VALUE; // (R15)
      fsm_reset <= `HSSP_RESET_VALUE;
      op_state <= `HSSP_RESET_VALUE;
      pin_ctrl <= `HSSP_RESET_VALUE;
      pin_dir_data <= `HSSP_RESET_VALUE;
      pin_pol_trig <= `HSSP_RESET_VALUE;
      pin_pull <= `HSSP_RESET_VALUE;
      for (i = 0; i < 4; i = i + 1) begin
        flags[i] <= `HSSP_RESET_VALUE;
        enables[i] <= `HSSP_RESET_VALUE;
      end
      cal_busy <= 1'b1;
      init_done <= 1'b0;
      cal_cnt <= 32'd0;
    end else begin
      if (cal_busy) begin
        cal_cnt <= cal_cnt + 32'd1;
        if (ready_evt) begin
          cal_busy <= 1'b0;
          init_done <= 1'b1;
        end
      end
      // flag clears by writing zero; a same-cycle event still sets
      for (i = 0; i < 4; i = i + 1) begin
        if (hit_low && wa[3:2] == 2'b01 && wa[1:0] == i[1:0]) begin
          flags[i] <= ((flags[i] & wd) | set_bits[i]) & wmask(i[1:0]); // (R18)
        end else begin
          flags[i] <= (flags[i] | set_bits[i]) & wmask(i[1:0]);
        end
        if (hit_low && wa[3:2] == 2'b10 && wa[1:0] == i[1:0]) begin
          enables[i] <= wd & wmask(i[1:0]); // (R18)
        end
      end
      if (hit_low) begin
        if (wa[3:0] == `HSSP_REG_RESET_CTRL) begin
          reset_ctrl <= wd & `HSSP_WMASK_RESET_CTRL; // (R18)
        end else if (wa[3:0] == `HSSP_REG_FSM_RESET) begin
          fsm_reset <= wd & `HSSP_WMASK_FSM_RESET;
        end else if (wa[3:0] == `HSSP_REG_OP_STATE) begin
          op_state <= wd & `HSSP_WMASK_OP_STATE;
        end else if (wa[3:0] == `HSSP_REG_PIN_CTRL) begin
          pin_ctrl <= wd & `HSSP_WMASK_PIN_CTRL; // (R7)
        end else if (wa[3:0] == `HSSP_REG_PIN_DIR_DATA) begin
          pin_dir_data <= wd & `HSSP_WMASK_PIN_DIR; // (R3)
        end else if (wa[3:0] == `HSSP_REG_PIN_POL_TRIG) begin
          pin_pol_trig <= wd & `HSSP_WMASK_PIN_POL; // (R5)
        end else if (wa[3:0] == `HSSP_REG_PIN_PULL) begin
          pin_pull <= wd & `HSSP_WMASK_PIN_PULL;
        end
      end
    end
  end

  // input filter: with schmitt on, a level must hold two samples to pass
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev <= 3'b000;
      pin_lvl <= 3'b000;
      pin_lvl_d <= 3'b000;
    end else begin
      pin_prev <= pin_s;
      pin_lvl_d <= pin_lvl;
      for (j = 0; j < 3; j = j + 1) begin
        if (!pin_pol_trig[j] || pin_s[j] == pin_prev[j]) begin
          pin_lvl[j] <= pin_s[j]; // (R6)
        end
      end
    end
  end

  // pin outputs and interrupt line, all registered
  wire [3:0] mon_sel = pin_ctrl[3:0];
  wire [5:0] mon_base = {1'b0, mon_sel, 1'b0} + {2'b00, mon_sel};
  wire [2:0] mon_bits = mon_i[mon_base +: 3];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_n_o <= 1'b1;
      pin_o <= 3'b000;
      pin_oe_n_o <= 3'b111;
      sdo_oe_n_o <= 1'b1;
    end else begin
      int_n_o <= ~(pin_ctrl[`HSSP_BIT_GIE] & pending); // (R1) (R2)
      pin_o <= (mon_sel == 4'h0) ? pin_dir_data[2:0] : mon_bits; // (R4) (R7)
      pin_oe_n_o <= ~({3{pin_dir_data[`HSSP_BIT_PIN_EN]}} & ~pin_dir_data[6:4]); // (R3)
      sdo_oe_n_o <= cs_s | deep_sleep_i; // (R12)
    end
  end

endmodule // hssp_system_port

// file: sim/hssp_system_port_assertions.sv
// Purpose: port checks of the system port
// Assumes: only the top pins are seen
// Notes: windows allow for the two-flop sync lag
`timescale 1ns/1ps
module hssp_system_port_assertions #(
  parameter MON_WIDTH = 48
) (
  input wire clk_i,
  input wire rst_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire sdi_i,
  input wire [2:0] pin_i,
  input wire [31:0] evt_i,
  input wire [MON_WIDTH-1:0] mon_i,
  input wire deep_sleep_i,
  input wire sdo_o,
  input wire sdo_oe_n_o,
  input wire int_n_o,
  input wire [2:0] pin_o,
  input wire [2:0] pin_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_SDO_SLEEP: assert property (deep_sleep_i [*2] |-> sdo_oe_n_o)
    else $error("sdo driven in sleep");
  AST_SDO_IDLE: assert property (cs_n_i [*5] |-> sdo_oe_n_o)
    else $error("sdo driven while deselected");
  AST_SDO_HOLD: assert property ((!cs_n_i && sck_i) [*6] |=> $stable(sdo_o))
    else $error("sdo moved while sck high");
  AST_RESET_DIR: assert property (!reset_n_i [*5] |=> pin_oe_n_o == 3'b111)
    else $error("pins driven in reset");
  AST_RESET_INT: assert property ($fell(reset_n_i) |-> ##[4:6] int_n_o)
    else $error("int kept low over reset");
  AST_DIR_STABLE: assert property ((cs_n_i && reset_n_i) [*8] |=> $stable(pin_oe_n_o))
    else $error("direction moved without write");
  AST_INT_STABLE: assert property ((cs_n_i && reset_n_i && evt_i == 32'h0 && $stable(pin_i)) [*8]
    |=> $stable(int_n_o))
    else $error("int moved without cause");
  AST_PIN_HOLD: assert property ((cs_n_i && reset_n_i && $stable(mon_i)) [*8] |=> $stable(pin_o))
    else $error("pin output moved without cause");
endmodule // hssp_system_port_assertions
bind hssp_system_port hssp_system_port_assertions #(.MON_WIDTH(MON_WIDTH)) hssp_system_port_assertions_i (
  .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .sdi_i(sdi_i),
  .pin_i(pin_i), .evt_i(evt_i), .mon_i(mon_i), .deep_sleep_i(deep_sleep_i), .sdo_o(sdo_o),
  .sdo_oe_n_o(sdo_oe_n_o), .int_n_o(int_n_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));

// file: sim/hssp_host_model.sv
// Purpose: host serial master model
// Assumes: mode 0,0, 160 ns serial clock
// Notes: data line flips on release so stale bits never pass
`timescale 1ns/1ps
module hssp_host_model (
  input wire clk_i,
  input wire sdo_i,
  input wire sdo_oe_n_i,
  output reg cs_n_o,
  output reg sck_o,
  output reg sdi_o
);
  reg drove;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    drove = 1'b0;
  end
  task clr;
    drove = 1'b0;
  endtask
  task half;
    repeat (8) @(negedge clk_i);
  endtask
  task sel;
    half;
    cs_n_o = 1'b0;
    half;
  endtask
  task desel;
    half;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    half;
  endtask
  task xb(input [7:0] t, output [7:0] r);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      sdi_o = t[i];
      half;
      sck_o = 1'b1;
      // a released line reads inverted so stale bits never pass
      r[i] = sdo_i ^ sdo_oe_n_i;
      drove = drove | ~sdo_oe_n_i;
      half;
      sck_o = 1'b0;
    end
  endtask
endmodule // hssp_host_model

// file: sim/hssp_system_port_tb.sv
// Purpose: self-checking bench of the system port
// Assumes: host model drives the serial pins
// Notes: short calibration count keeps the run brief
`timescale 1ns/1ps
module hssp_system_port_tb;
  reg clk_i;
  reg rst_i;
  reg reset_n_i;
  reg deep_sleep_i;
  reg [2:0] pin_i;
  reg [31:0] evt_i;
  wire cs_n, sck, sdi, sdo, sdo_oe_n, int_n_o;
  wire [2:0] pin_o, pin_oe_n_o;
  integer err_total = 0;
  integer num_checks = 0;
  reg [7:0] q;
  hssp_system_port #(.CAL_CYCLES(20)) hssp_system_port_i (.clk_i(clk_i), .rst_i(rst_i),
    .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi), .pin_i(pin_i), .evt_i(evt_i),
    .mon_i(48'h18), .deep_sleep_i(deep_sleep_i), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
    .int_n_o(int_n_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
  hssp_host_model hssp_host_model_i (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n),
    .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wt(input integer n);
    repeat (n) @(negedge clk_i);
  endtask
  task xf(input [7:0] c0, input [7:0] c1, input two, input [7:0] d, output [7:0] d_o);
    reg [7:0] r;
    hssp_host_model_i.sel;
    hssp_host_model_i.xb(c0, r);
    if (two) hssp_host_model_i.xb(c1, r);
    hssp_host_model_i.xb(d, d_o);
    hssp_host_model_i.desel;
  endtask
  task wr(input [5:0] a, input [7:0] d);
    xf({1'b0, a, 1'b1}, 8'h00, 1'b0, d, q);
  endtask
  task rd(input [5:0] a, input [7:0] exp);
    xf({1'b0, a, 1'b0}, 8'h00, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask
  task t_pins;
    wr(6'h0d, 8'had);
    chk({5'h0, pin_oe_n_o}, 8'h02);
    chk({6'h0, pin_o[2], pin_o[0]}, 8'h03);
    hssp_host_model_i.sel;
    hssp_host_model_i.xb(8'h1a, q);
    hssp_host_model_i.xb(8'h00, q);
    chk(q, 8'ha5);
    hssp_host_model_i.xb(8'h00, q);
    chk(q, 8'h00);
    hssp_host_model_i.desel;
    wr(6'h0c, 8'h01);
    chk({6'h0, pin_o[2], pin_o[0]}, 8'h01);
    wr(6'h0c, 8'h00);
  endtask
  task t_irq(input [4:0] b);
    wt(1);
    evt_i[b] = 1'b1;
    wt(1);
    evt_i = 32'h0;
    wt(4);
  endtask
  task t_int;
    wr(6'h0b, 8'h01);
    t_irq(5'd25);
    chk({7'h0, int_n_o}, 8'h01);
    t_irq(5'd24);
    chk({7'h0, int_n_o}, 8'h01);
    xf(8'hc0, 8'h0c, 1'b1, 8'h40, q);
    chk({7'h0, int_n_o}, 8'h00);
    xf(8'h80, 8'h07, 1'b1, 8'h00, q);
    chk(q, 8'h03);
    rd(6'h0c, 8'h50);
    wr(6'h07, 8'hfe);
    chk({7'h0, int_n_o}, 8'h01);
    wr(6'h10, 8'hff);
    rd(6'h10, 8'h00);
    rd(6'h3f, 8'h00);
  endtask
  task t_sleep;
    deep_sleep_i = 1'b1;
    hssp_host_model_i.clr;
    xf(8'h1a, 8'h00, 1'b0, 8'h00, q);
    chk({7'h0, hssp_host_model_i.drove}, 8'h00);
    deep_sleep_i = 1'b0;
    rd(6'h0d, 8'ha5);
    chk({7'h0, hssp_host_model_i.drove}, 8'h01);
  endtask
  task t_reset_pin;
    reset_n_i = 1'b0;
    wt(10);
    chk({5'h0, pin_oe_n_o}, 8'h07);
    reset_n_i = 1'b1;
    wt(40);
    rd(6'h04, 8'h20);
    rd(6'h03, 8'h80);
    wr(6'h0e, 8'h99);
    rd(6'h0e, 8'h11);
    pin_i[0] = 1'b0;
    wt(10);
    rd(6'h07, 8'h00);
    pin_i[0] = 1'b1;
    wt(10);
    rd(6'h07, 8'h01);
    wr(6'h07, 8'h00);
    pin_i[0] = 1'b0;
    wt(1);
    pin_i[0] = 1'b1;
    wt(10);
    rd(6'h07, 8'h00);
  endtask
  initial begin
    rst_i = 1'b1;
    reset_n_i = 1'b1;
    deep_sleep_i = 1'b0;
    pin_i = 3'b101;
    evt_i = 32'h0;
    wt(12);
    rst_i = 1'b0;
    wt(40);
    rd(6'h04, 8'h20);
    t_pins;
    t_int;
    t_sleep;
    t_reset_pin;
    print_verdict;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    print_verdict;
  end
endmodule // hssp_system_port_tb
